// File: pkg/dsp_consts.vh
// Constants for the dual-slope PWM compare unit: offsets, fields, resets.
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave.
`define DSP_OFF_CTRL 8'h00
`define DSP_OFF_COUNT 8'h04
`define DSP_OFF_CMP_A 8'h08
`define DSP_OFF_CMP_B 8'h0c
`define DSP_OFF_FLAGS 8'h10
`define DSP_OFF_FORCE 8'h14
`define DSP_OFF_STATUS 8'h18

// Control register field positions.
`define DSP_CTRL_MODE_LO 0
`define DSP_CTRL_ACT_A_LO 4
`define DSP_CTRL_ACT_B_LO 6
`define DSP_CTRL_PRE_LO 8
`define DSP_CTRL_PORT_A 12
`define DSP_CTRL_PORT_B 13
`define DSP_CTRL_DIR_A 14
`define DSP_CTRL_DIR_B 15
`define DSP_CTRL_IEN_A 16
`define DSP_CTRL_IEN_B 17
`define DSP_CTRL_IEN_WRAP 18
`define DSP_CTRL_MASK 32'h0007_f7f7

// Flag register bit positions; A and B are also the force strobe positions.
`define DSP_FLAG_A 0
`define DSP_FLAG_B 1
`define DSP_FLAG_WRAP 2

// Reset values.
`define DSP_CTRL_RESET 32'h0000_0000
`define DSP_COUNT_RESET 8'h00
`define DSP_CMP_RESET 8'h00

// Waveform mode codes.
`define DSP_MODE_NORMAL 3'h0
`define DSP_MODE_PC_FF 3'h1
`define DSP_MODE_CTC 3'h2
`define DSP_MODE_FAST_FF 3'h3
`define DSP_MODE_PC_A 3'h5
`define DSP_MODE_FAST_A 3'h7

// Fixed counter limits.
`define DSP_MAX 8'hff
`define DSP_BOTTOM 8'h00

// Prescaler masks: a tick when the masked prescale count is all ones.
`define DSP_PRE_DIV1 10'h000
`define DSP_PRE_DIV8 10'h007
`define DSP_PRE_DIV32 10'h01f
`define DSP_PRE_DIV64 10'h03f
`define DSP_PRE_DIV128 10'h07f
`define DSP_PRE_DIV256 10'h0ff
`define DSP_PRE_DIV1024 10'h3ff

// Bus response codes.
`define DSP_RESP_OKAY 2'h0
`define DSP_RESP_SLVERR 2'h2

`endif

// File: verilog/dsp_pwm_unit.v
// Timer with two compare channels, dual-slope PWM and an AXI4-Lite slave.
//
// How it works
// - Modes 1 and 5 run phase correct, top FF/A.
// - Count up to top, down to bottom, repeat.
// - Counter reverses at top and bottom, holding neither.
// - Non-inverting clears on up match, sets down.
// - Action two non-inverted, three inverted PWM.
// - Wrap flag set at bottom in phase correct, at top in fast, else at FF.
// - Phase correct non-inverting: compare bottom stays low, max stays high.
// - Missed up match still gives its transition.
// - Period 510 ticks at top FF; prescale 1 to 1024.
// - Equality sets channel flag next timer cycle.
// - Enabled flag requests interrupt; ack/write-one clears.
// - PWM modes buffer compares, update at top.
// - Software reaches buffer or active compare register.
// - Force strobe acts like match outside PWM modes, no flag.
// - Counter write blocks matches for next tick.
// - Output action select changes act immediately.
// - Compare output keeps value across mode changes.
// - Nonzero action select overrides port output value.
// - Compare at top: ignore match, act at top.
`include "dsp_consts.vh"

module dsp_pwm_unit (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire irq_ack_a,
  input wire irq_ack_b,
  input wire irq_ack_wrap,
  output wire irq_req_a,
  output wire irq_req_b,
  output wire irq_req_wrap,
  output reg pin_out_a,
  output reg pin_oe_a,
  output reg pin_out_b,
  output reg pin_oe_b
);

  // Merges write data into an old word under the byte strobes.
  function [31:0] dsp_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      dsp_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          dsp_merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  reg [7:0] aw_addr;
  reg aw_full;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_full;
  reg [31:0] ctrl;
  reg [7:0] count_value;
  reg count_down;
  reg block_match;
  reg [9:0] pre_cnt;
  reg wrap_flag;
  reg [31:0] rd_word;
  reg rd_hit;
  wire do_wr;
  wire [31:0] wr_word;
  wire wr_ok;
  wire [2:0] waveform_mode_sel;
  wire [2:0] pre_sel;
  wire phase_mode;
  wire fast_mode;
  wire pwm_mode;
  wire top_from_a;
  wire [7:0] top;
  wire tick;
  wire count_wr;
  wire match_ok;
  wire at_top;
  wire at_bottom;
  wire wrap_event;
  wire cmp_update;
  wire flags_wr;
  wire force_wr;
  reg [9:0] pre_mask;
  wire [15:0] cmp_act_all;
  wire [15:0] cmp_buf_all;
  wire [1:0] oc_all;
  wire [1:0] flag_all;

  assign waveform_mode_sel = ctrl[`DSP_CTRL_MODE_LO +: 3];
  assign pre_sel = ctrl[`DSP_CTRL_PRE_LO +: 3];

  // Mode decode; only 1 and 5 are dual-slope.
  assign phase_mode = (waveform_mode_sel == `DSP_MODE_PC_FF) ||
                      (waveform_mode_sel == `DSP_MODE_PC_A);
  assign fast_mode = (waveform_mode_sel == `DSP_MODE_FAST_FF) ||
                     (waveform_mode_sel == `DSP_MODE_FAST_A);
  assign pwm_mode = phase_mode | fast_mode;
  assign top_from_a = (waveform_mode_sel == `DSP_MODE_PC_A) ||
                      (waveform_mode_sel == `DSP_MODE_CTC) ||
                      (waveform_mode_sel == `DSP_MODE_FAST_A);
  assign top = top_from_a ? cmp_act_all[7:0] : `DSP_MAX;

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = ~aw_full;
  assign s_axi_wready = ~w_full;
  assign do_wr = aw_full & w_full & ~s_axi_bvalid;
  assign wr_word = w_data;
  assign wr_ok = (aw_addr == `DSP_OFF_CTRL) ||
                 (aw_addr == `DSP_OFF_COUNT) ||
                 (aw_addr == `DSP_OFF_CMP_A) ||
                 (aw_addr == `DSP_OFF_CMP_B) ||
                 (aw_addr == `DSP_OFF_FLAGS) ||
                 (aw_addr == `DSP_OFF_FORCE) ||
                 (aw_addr == `DSP_OFF_STATUS);
  assign count_wr = do_wr & (aw_addr == `DSP_OFF_COUNT) & w_strb[0];
  assign flags_wr = do_wr & (aw_addr == `DSP_OFF_FLAGS) & w_strb[0];
  assign force_wr = do_wr & (aw_addr == `DSP_OFF_FORCE) & w_strb[0];

  // Holds write address and data until both are present.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `DSP_RESP_OKAY : `DSP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; action select bits take effect at once.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DSP_CTRL_RESET;
    end else if (do_wr && aw_addr == `DSP_OFF_CTRL) begin
      ctrl <= dsp_merge(ctrl, wr_word, w_strb) & `DSP_CTRL_MASK;
    end
  end

  // Prescaler mask for the selectable division factors.
  always @* begin
    case (pre_sel)
      3'h1: pre_mask = `DSP_PRE_DIV1;
      3'h2: pre_mask = `DSP_PRE_DIV8;
      3'h3: pre_mask = `DSP_PRE_DIV32;
      3'h4: pre_mask = `DSP_PRE_DIV64;
      3'h5: pre_mask = `DSP_PRE_DIV128;
      3'h6: pre_mask = `DSP_PRE_DIV256;
      3'h7: pre_mask = `DSP_PRE_DIV1024;
      default: pre_mask = `DSP_PRE_DIV1;
    endcase
  end

  // Free-running prescale count; a selection of zero stops the timer.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 10'h000;
    end else if (pre_sel == 3'h0) begin
      pre_cnt <= 10'h000;
    end else begin
      pre_cnt <= pre_cnt + 10'h001;
    end
  end

  assign tick = (pre_sel != 3'h0) &&
                ((pre_cnt & pre_mask) == pre_mask);

  // Counter events seen on a tick.
  assign at_top = tick & (count_value == top);
  assign at_bottom = tick & phase_mode & count_down &
                     (count_value == `DSP_BOTTOM);
  assign wrap_event = phase_mode ? at_bottom :
                      (fast_mode ? at_top :
                       (tick & (count_value == `DSP_MAX)));
  assign cmp_update = at_top & (fast_mode | (phase_mode & ~count_down));
  assign match_ok = tick & ~block_match;

  // Counter: dual-slope in phase correct modes, single slope otherwise.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= `DSP_COUNT_RESET;
      count_down <= 1'b0;
    end else if (count_wr) begin
      count_value <= wr_word[7:0];
    end else if (tick) begin
      if (phase_mode) begin
        if (!count_down) begin
          if (count_value == top) begin
            count_down <= 1'b1;
            count_value <= count_value - 8'h01;
          end else begin
            count_value <= count_value + 8'h01;
          end
        end else if (count_value == `DSP_BOTTOM) begin
          count_down <= 1'b0;
          count_value <= count_value + 8'h01;
        end else begin
          count_value <= count_value - 8'h01;
        end
      end else begin
        count_down <= 1'b0;
        if (waveform_mode_sel != `DSP_MODE_NORMAL && count_value == top &&
            (top_from_a || fast_mode)) begin
          count_value <= `DSP_BOTTOM;
        end else begin
          count_value <= count_value + 8'h01;
        end
      end
    end
  end

  // Match blocking after a software counter write, held while stopped.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_match <= 1'b0;
    end else if (count_wr) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // Wrap flag; a set in the clearing cycle wins.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_flag <= 1'b0;
    end else begin
      wrap_flag <= (wrap_flag & ~irq_ack_wrap &
                    ~(flags_wr & wr_word[`DSP_FLAG_WRAP])) |
                   wrap_event;
    end
  end

  // Per-channel compare registers, flag and waveform output.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg [7:0] cmp_act;
      reg [7:0] cmp_buf;
      reg match_flag;
      reg compare_output;
      reg up_seen;
      wire [1:0] output_action_sel;
      wire cmp_wr;
      wire match;
      wire clr;
      wire at_cmp_top;
      wire toggle_ok;
      assign output_action_sel = ctrl[`DSP_CTRL_ACT_A_LO + 2*ch +: 2];
      assign cmp_wr = do_wr & w_strb[0] & (aw_addr ==
                      (ch == 0 ? `DSP_OFF_CMP_A : `DSP_OFF_CMP_B));
      assign match = match_ok & (count_value == cmp_act);
      assign clr = (ch == 0 ? irq_ack_a : irq_ack_b) |
                   (flags_wr & wr_word[ch]);
      assign at_cmp_top = (cmp_act == top);
      assign toggle_ok = (ch == 0) & waveform_mode_sel[2];

      // Compare value: buffered in PWM modes, direct otherwise.
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          cmp_act <= `DSP_CMP_RESET;
          cmp_buf <= `DSP_CMP_RESET;
        end else begin
          if (cmp_update) begin
            cmp_act <= cmp_buf;
          end
          if (cmp_wr) begin
            cmp_buf <= wr_word[7:0];
            if (!pwm_mode) begin
              cmp_act <= wr_word[7:0];
            end
          end
        end
      end

      // Match flag; a set in the clearing cycle wins.
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          match_flag <= 1'b0;
        end else begin
          match_flag <= (match_flag & ~clr) | match;
        end
      end

      // Waveform generator; mode changes leave the output untouched.
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          compare_output <= 1'b0;
          up_seen <= 1'b0;
        end else if (!pwm_mode) begin
          if (match || (force_wr && wr_word[ch])) begin
            case (output_action_sel)
              2'h1: compare_output <= ~compare_output;
              2'h2: compare_output <= 1'b0;
              2'h3: compare_output <= 1'b1;
              default: compare_output <= compare_output;
            endcase
          end
        end else if (fast_mode) begin
          if (output_action_sel[1]) begin
            if (at_top) begin
              compare_output <= ~output_action_sel[0];
            end else if (match && !at_cmp_top) begin
              compare_output <= output_action_sel[0];
            end
          end else if (output_action_sel[0] && toggle_ok && match) begin
            compare_output <= ~compare_output;
          end
        end else if (output_action_sel[1]) begin
          if (match && !at_cmp_top) begin
            if (!count_down || count_value == `DSP_BOTTOM) begin
              compare_output <= output_action_sel[0];
              up_seen <= 1'b1;
            end else begin
              compare_output <= ~output_action_sel[0];
            end
          end else if (at_top && !count_down && at_cmp_top) begin
            compare_output <= ~output_action_sel[0];
          end else if (tick && !count_down && !up_seen &&
                       count_value > cmp_act) begin
            compare_output <= output_action_sel[0];
            up_seen <= 1'b1;
          end else if (at_bottom) begin
            up_seen <= 1'b0;
          end
        end else if (output_action_sel[0] && toggle_ok && match) begin
          compare_output <= ~compare_output;
        end
      end

      assign cmp_act_all[ch*8 +: 8] = cmp_act;
      assign cmp_buf_all[ch*8 +: 8] = cmp_buf;
      assign oc_all[ch] = compare_output;
      assign flag_all[ch] = match_flag;
    end
  endgenerate

  // Interrupt requests from enabled flags.
  assign irq_req_a = flag_all[0] & ctrl[`DSP_CTRL_IEN_A];
  assign irq_req_b = flag_all[1] & ctrl[`DSP_CTRL_IEN_B];
  assign irq_req_wrap = wrap_flag & ctrl[`DSP_CTRL_IEN_WRAP];

  // Pin drive: compare output replaces the port value, direction stays.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_a <= 1'b0;
      pin_oe_a <= 1'b0;
      pin_out_b <= 1'b0;
      pin_oe_b <= 1'b0;
    end else begin
      pin_out_a <= (ctrl[`DSP_CTRL_ACT_A_LO +: 2] != 2'h0) ? oc_all[0] :
                   ctrl[`DSP_CTRL_PORT_A];
      pin_oe_a <= ctrl[`DSP_CTRL_DIR_A];
      pin_out_b <= (ctrl[`DSP_CTRL_ACT_B_LO +: 2] != 2'h0) ? oc_all[1] :
                   ctrl[`DSP_CTRL_PORT_B];
      pin_oe_b <= ctrl[`DSP_CTRL_DIR_B];
    end
  end

  // Read decode; compare reads see the buffer while it is in use.
  always @* begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      `DSP_OFF_CTRL: rd_word = ctrl;
      `DSP_OFF_COUNT: rd_word = {24'h000000, count_value};
      `DSP_OFF_CMP_A: rd_word = {24'h000000,
        pwm_mode ? cmp_buf_all[7:0] : cmp_act_all[7:0]};
      `DSP_OFF_CMP_B: rd_word = {24'h000000,
        pwm_mode ? cmp_buf_all[15:8] : cmp_act_all[15:8]};
      `DSP_OFF_FLAGS: rd_word = {29'h00000000, wrap_flag, flag_all};
      `DSP_OFF_FORCE: rd_word = 32'h0000_0000;
      `DSP_OFF_STATUS: rd_word = {29'h00000000, oc_all, count_down};
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // Read channel: one read at a time, answered the cycle after.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DSP_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `DSP_RESP_OKAY : `DSP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: sim/dsp_pwm_chk.sv
// Checker of bus handshakes and pin enables of the PWM compare unit.
`include "dsp_consts.vh"
module dsp_pwm_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire pin_oe_a,
  input wire pin_oe_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] want;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ctrl_wr = aw_hs && w_hs && s_axi_wstrb[1] &&
    (s_axi_awaddr[7:2] == 6'h00);
  // Keeps the pin enables that the last control write asked for.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      want <= 2'h0;
    end else if (ctrl_wr) begin
      want <= s_axi_wdata[15:14];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ar_refused;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refused: assert property (p_ar_refused)
    else $error("read address taken while a read is pending");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data late");
  property p_read_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_read_done: assert property (p_read_done)
    else $error("read data repeated");
  property p_aw_refused;
    aw_hs |=> !s_axi_awready;
  endproperty
  a_aw_refused: assert property (p_aw_refused)
    else $error("write address ready while one is held");
  property p_w_refused;
    w_hs |=> !s_axi_wready;
  endproperty
  a_w_refused: assert property (p_w_refused)
    else $error("write data ready while one is held");
  property p_write_answer;
    aw_hs && w_hs |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");
  property p_write_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_write_done: assert property (p_write_done)
    else $error("write response repeated");
  property p_oe_a;
    ctrl_wr |-> ##[2:4] (pin_oe_a == want[0]);
  endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("pin A drive enable does not follow control");
  property p_oe_b;
    ctrl_wr |-> ##[2:4] (pin_oe_b == want[1]);
  endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("pin B drive enable does not follow control");
endmodule

bind dsp_pwm_unit dsp_pwm_chk u_chk (.ref_clk, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .pin_oe_a, .pin_oe_b);

// File: sim/dsp_load_model.sv
// Model of the external load on one compare pin, with a pull-down.
module dsp_load_model (
  input wire ref_clk,
  input wire clear,
  input wire drive,
  input wire oe,
  output wire line,
  output logic [15:0] high_cnt,
  output logic [15:0] rise_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  // A released pin is pulled low by the load resistor.
  assign line = oe ? drive : 1'b0;
  // Counts cycles at the high level and rising edges seen by the load.
  always @(posedge ref_clk) begin
    if (clear) begin
      high_cnt <= 16'h0;
      rise_cnt <= 16'h0;
    end else begin
      high_cnt <= high_cnt + {15'h0, line};
      rise_cnt <= rise_cnt + {15'h0, line & !last};
    end
    last <= line;
  end
endmodule

// File: sim/dsp_pwm_unit_bench.sv
// Self-checking bench of the PWM compare unit with loads on both pins.
`include "dsp_consts.vh"
module dsp_pwm_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic irq_ack_a = 1'b0;
  logic clr = 1'b0;
  logic [31:0] rd;
  logic [1:0] rsp;
  int mismatches = 0;
  int checked = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, irq_req_a, pin_out_a, pin_oe_a, pin_out_b, pin_oe_b;
  wire irq_req_b, irq_req_wrap;
  wire line_a, line_b;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] hi_a, hi_b, rise_a, rise_b;

  dsp_pwm_unit u_dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_ack_a,
    .irq_ack_b(irq_ack_a), .irq_ack_wrap(irq_ack_a), .irq_req_a,
    .irq_req_b, .irq_req_wrap, .pin_out_a, .pin_oe_a, .pin_out_b,
    .pin_oe_b);
  dsp_load_model u_load_a (.ref_clk, .clear(clr), .drive(pin_out_a),
    .oe(pin_oe_a), .line(line_a), .high_cnt(hi_a), .rise_cnt(rise_a));
  dsp_load_model u_load_b (.ref_clk, .clear(clr), .drive(pin_out_b),
    .oe(pin_oe_b), .line(line_b), .high_cnt(hi_b), .rise_cnt(rise_b));

  // Makes the 25 MHz clock.
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Writes one word, address and data offered together.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      aw |= s_axi_awready;
      w |= s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Reads one word into rd and its response into rsp.
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Clears the load counters and lets them run for n cycles.
  task automatic meas(input int n);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Reset values and the unmapped offset.
  task automatic t_reset;
    rdr(`DSP_OFF_CTRL);
    check("ctrl", rd, `DSP_CTRL_RESET);
    rdr(`DSP_OFF_STATUS);
    check("status", rd, 32'h0);
    rdr(8'h1c);
    check("bad rd", {rd[29:0], rsp}, {30'h0, `DSP_RESP_SLVERR});
    wr(8'h1c, 32'hffff_ffff);
    check("bad wr", {30'h0, rsp}, {30'h0, `DSP_RESP_SLVERR});
  endtask

  // Force strobes in normal mode, pin override and mode change.
  task automatic t_force;
    wr(`DSP_OFF_CTRL, 32'h30);
    wr(`DSP_OFF_FORCE, 32'h1);
    rdr(`DSP_OFF_STATUS);
    check("force set", rd, 32'h2);
    rdr(`DSP_OFF_FLAGS);
    check("force flag", rd, 32'h0);
    wr(`DSP_OFF_CTRL, 32'h20);
    wr(`DSP_OFF_FORCE, 32'h1);
    rdr(`DSP_OFF_STATUS);
    check("force clr", rd, 32'h0);
    wr(`DSP_OFF_CTRL, 32'h10);
    wr(`DSP_OFF_FORCE, 32'h1);
    rdr(`DSP_OFF_STATUS);
    check("force tgl", rd, 32'h2);
    wr(`DSP_OFF_CTRL, 32'h4010);
    repeat (2) @(posedge ref_clk);
    check("override", {31'h0, line_a}, 32'h1);
    wr(`DSP_OFF_CTRL, 32'h4000);
    repeat (2) @(posedge ref_clk);
    check("port", {31'h0, line_a}, 32'h0);
    wr(`DSP_OFF_CTRL, 32'h1);
    rdr(`DSP_OFF_STATUS);
    check("keep", rd & 32'h2, 32'h2);
  endtask

  // Count write blocking, match flag, acknowledge and write-one-clear.
  task automatic t_block;
    wr(`DSP_OFF_CTRL, 32'h0);
    wr(`DSP_OFF_CMP_A, 32'h5);
    rdr(`DSP_OFF_CMP_A);
    check("cmp direct", rd, 32'h5);
    wr(`DSP_OFF_COUNT, 32'h5);
    // All three requests enabled; compare B at zero and the wrap both fire.
    wr(`DSP_OFF_CTRL, 32'h7_0100);
    repeat (20) @(posedge ref_clk);
    rdr(`DSP_OFF_FLAGS);
    check("blocked", {31'h0, rd[0]}, 32'h0);
    repeat (300) @(posedge ref_clk);
    rdr(`DSP_OFF_FLAGS);
    check("match", {31'h0, rd[0]}, 32'h1);
    check("irq", {31'h0, irq_req_a}, 32'h1);
    check("irq b", {31'h0, irq_req_b}, 32'h1);
    check("irq wrap", {31'h0, irq_req_wrap}, 32'h1);
    @(posedge ref_clk);
    irq_ack_a <= 1'b1;
    @(posedge ref_clk);
    irq_ack_a <= 1'b0;
    rdr(`DSP_OFF_FLAGS);
    check("ack", {29'h0, rd[2:0]}, 32'h0);
    repeat (260) @(posedge ref_clk);
    wr(`DSP_OFF_FLAGS, 32'h1);
    rdr(`DSP_OFF_FLAGS);
    check("w1c", {31'h0, rd[0]}, 32'h0);
    wr(`DSP_OFF_CTRL, 32'h0);
  endtask

  // Phase correct waveforms on both pins, measured by the loads.
  task automatic t_pc;
    logic [7:0] cv [5] = '{8'h40, 8'h40, 8'h00, 8'hff, 8'h00};
    logic [1:0] ac [5] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3};
    logic [15:0] eh [5] = '{16'h100, 16'h2fc, 16'h0, 16'h3fc, 16'h3fc};
    logic [15:0] er [5] = '{16'h2, 16'h2, 16'h0, 16'h0, 16'h0};
    for (int i = 0; i < 5; i++) begin
      wr(`DSP_OFF_CTRL, 32'h4101 | {26'h0, ac[i], 4'h0});
      wr(`DSP_OFF_CMP_A, {24'h0, cv[i]});
      rdr(`DSP_OFF_CMP_A);
      check("buffer", rd, {24'h0, cv[i]});
      // A new compare lands at the next top; its level up to a top later.
      repeat (1100) @(posedge ref_clk);
      meas(1020);
      check("high a", {16'h0, hi_a}, {16'h0, eh[i]});
      check("rise a", {16'h0, rise_a}, {16'h0, er[i]});
    end
    wr(`DSP_OFF_CMP_A, 32'h64);
    wr(`DSP_OFF_CMP_B, 32'h28);
    // The ceiling may still be the old compare A until the next top.
    wr(`DSP_OFF_CTRL, 32'h8185);
    repeat (1100) @(posedge ref_clk);
    meas(1000);
    check("high b", {16'h0, hi_b}, 32'h190);
    check("rise b", {16'h0, rise_b}, 32'h5);
    wr(`DSP_OFF_FLAGS, 32'h7);
    repeat (250) @(posedge ref_clk);
    rdr(`DSP_OFF_FLAGS);
    check("wrap", rd & 32'h4, 32'h4);
  endtask

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #1200000;
    mismatches++;
    finish_test();
  end

  // Main sequence after six cycles of reset.
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_force();
    t_block();
    t_pc();
    finish_test();
  end
endmodule
